// File: rtl/alo_pkg.sv
// Purpose: Shared constants and types for the accumulator logic unit.
// Assumes: 20 MHz controller clock, one operation per accepted request.
// Notes:   Operation codes are chosen locally.
package alo_pkg;
    localparam int ACC_W        = 32;
    localparam int WORD_W       = 16;
    localparam int CNT_W        = 6;
    localparam int STACK_DEPTH  = 8;
    localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
    localparam logic [CNT_W-1:0] BITS_MIN  = 6'h01;
    localparam logic [CNT_W-1:0] BITS_MAX  = 6'h20;

    typedef enum logic [2:0] {
        ALO_OR_DOUBLE,
        ALO_OR_BITRANGE,
        ALO_OR_STACK,
        ALO_XOR_WORD,
        ALO_XOR_DOUBLE,
        ALO_XOR_BITRANGE
    } alo_op_e;

    // Keeps only the low count bits of a discrete run; count outside 1..32 gives zero.
    function automatic logic [ACC_W-1:0] alo_run_mask(input logic [ACC_W-1:0] bits,
                                                      input logic [CNT_W-1:0] count);
        logic [ACC_W-1:0] mask;
        mask = '0;
        for (int i = 0; i < ACC_W; i++) begin
            if (count >= BITS_MIN && count <= BITS_MAX && i < int'(count)) begin
                mask[i] = 1'b1;
            end
        end
        return bits & mask;
    endfunction
endpackage

// File: rtl/alo_stack.sv
// Purpose: Accumulator stack storage with a pop that shifts all levels up.
// Assumes: Push comes from other instructions of the controller.
// Notes:   Pop and push in one cycle: pop wins, push is dropped.
`timescale 1ns/1ns
module alo_stack #(
    parameter int DEPTH = alo_pkg::STACK_DEPTH
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic                      push,
    input  wire logic [alo_pkg::ACC_W-1:0] push_data,
    input  wire logic                      pop,
    output logic      [alo_pkg::ACC_W-1:0] top
);
    import alo_pkg::*;

    logic [ACC_W-1:0] level      [DEPTH];
    logic [ACC_W-1:0] next_level [DEPTH];

    always_comb begin
        next_level = level;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_level[i] = level[i+1];
            end
            next_level[DEPTH-1] = ACC_RESET;
        end else if (push) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                next_level[i] = level[i-1];
            end
            next_level[0] = push_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                level[i] <= ACC_RESET;
            end
        end else begin
            level <= next_level;
        end
    end

    assign top = level[0];

    stack_shift_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pop |=> level[0] == $past(level[1]))
        else $error("Stack did not shift up on pop.");
endmodule // alo_stack

// File: rtl/alo_unit.sv
// Purpose: Accumulator OR and exclusive-OR unit with zero and negative flags.
// Assumes: Operands arrive valid with op_valid; rung condition given per request.
// Notes:   Every operation completes in the cycle after it is taken.
//          Push and load come from other instructions; a taken operation wins over a load.
`timescale 1ns/1ns
module alo_unit #(
    parameter int STACK_LEVELS = alo_pkg::STACK_DEPTH
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic                      op_valid,
    input  wire logic                      rung_true,
    input  wire alo_pkg::alo_op_e          op_code,
    input  wire logic [alo_pkg::ACC_W-1:0] operand,
    input  wire logic [alo_pkg::CNT_W-1:0] bit_count,
    input  wire logic                      acc_load,
    input  wire logic [alo_pkg::ACC_W-1:0] acc_load_data,
    input  wire logic                      stack_push,
    output logic      [alo_pkg::ACC_W-1:0] accumulator,
    output logic                           zero_flag,
    output logic                           negative_flag,
    output logic                           op_done
);
    import alo_pkg::*;

    logic [ACC_W-1:0] stack_top;
    logic [ACC_W-1:0] result;
    logic [ACC_W-1:0] next_accumulator;
    logic             next_zero_flag;
    logic             next_negative_flag;
    logic             next_op_done;
    logic             fire;
    logic             pop;

    // A request with its rung false is dropped whole: no result, no pop, no done pulse.
    // Rung gating.
    assign fire = op_valid && rung_true;
    assign pop  = fire && op_code == ALO_OR_STACK;

    // Stack push is blocked during a pop so a level is never lost silently.
    // The stack drops it as well; gating it here keeps the intent visible at this level.
    alo_stack #(
        .DEPTH(STACK_LEVELS)
    ) u_stack (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .push     (stack_push && !pop),
        .push_data(accumulator),
        .pop      (pop),
        .top      (stack_top)
    );

    always_comb begin
        result = accumulator;
        unique case (op_code)
            ALO_OR_DOUBLE:    result = accumulator | operand;
            ALO_OR_BITRANGE:  result = accumulator | alo_run_mask(operand, bit_count);
            ALO_OR_STACK:     result = accumulator | stack_top;
            ALO_XOR_WORD:     result = {accumulator[ACC_W-1:WORD_W],
                                        accumulator[WORD_W-1:0] ^ operand[WORD_W-1:0]};
            ALO_XOR_DOUBLE:   result = accumulator ^ operand;
            ALO_XOR_BITRANGE: result = accumulator ^ alo_run_mask(operand, bit_count);
            // Codes 6 and 7 are unused and leave the accumulator as it is.
            default:          result = accumulator;
        endcase
    end

    always_comb begin
        next_accumulator   = accumulator;
        next_zero_flag     = zero_flag;
        next_negative_flag = negative_flag;
        next_op_done       = fire;
        if (fire) begin
            next_accumulator   = result;
            // A word XOR still takes its flags from the whole 32-bit result.
            // Zero from result.
            next_zero_flag     = (result == '0);
            next_negative_flag = result[ACC_W-1];
        end else if (acc_load) begin
            // Loads from other instructions leave the flags to those instructions.
            next_accumulator = acc_load_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator   <= ACC_RESET;
            zero_flag     <= 1'b0;
            negative_flag <= 1'b0;
            op_done       <= 1'b0;
        end else begin
            accumulator   <= next_accumulator;
            zero_flag     <= next_zero_flag;
            negative_flag <= next_negative_flag;
            op_done       <= next_op_done;
        end
    end

    or_double_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fire && op_code == ALO_OR_DOUBLE) |=> accumulator == ($past(accumulator) | $past(operand)))
        else $error("Double OR result wrong.");

    or_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fire && op_code == ALO_OR_BITRANGE && bit_count == BITS_MIN)
        |=> accumulator[ACC_W-1:1] == $past(accumulator[ACC_W-1:1]))
        else $error("Single-bit OR touched upper bits.");

    or_full_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fire && op_code == ALO_OR_BITRANGE && bit_count == BITS_MAX)
        |=> accumulator == ($past(accumulator) | $past(operand)))
        else $error("Full-width range OR wrong.");

    or_stack_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pop |=> accumulator == ($past(accumulator) | $past(stack_top)))
        else $error("Stack OR result wrong.");

    xor_lower_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fire && op_code == ALO_XOR_WORD)
        |=> accumulator[WORD_W-1:0] == ($past(accumulator[WORD_W-1:0]) ^ $past(operand[WORD_W-1:0])))
        else $error("Word XOR low half wrong.");

    xor_upper_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fire && op_code == ALO_XOR_WORD) |=> accumulator[ACC_W-1:WORD_W] == $past(accumulator[ACC_W-1:WORD_W]))
        else $error("Word XOR changed upper half.");

    word_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fire && op_code == ALO_XOR_WORD) |=> zero_flag == (accumulator == '0))
        else $error("Word XOR zero flag wrong.");

    xor_double_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fire && op_code == ALO_XOR_DOUBLE) |=> accumulator == ($past(accumulator) ^ $past(operand)))
        else $error("Double XOR result wrong.");

    xor_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fire && op_code == ALO_XOR_BITRANGE && bit_count == BITS_MAX)
        |=> accumulator == ($past(accumulator) ^ $past(operand)))
        else $error("Full-width range XOR wrong.");

    xor_single_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fire && op_code == ALO_XOR_BITRANGE && bit_count == BITS_MIN)
        |=> accumulator == ($past(accumulator) ^ {{(ACC_W-1){1'b0}}, $past(operand[0])}))
        else $error("Single-bit range XOR wrong.");

    zero_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        op_done |-> zero_flag == (accumulator == '0))
        else $error("Zero flag disagrees with result.");

    neg_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        op_done |-> negative_flag == accumulator[ACC_W-1])
        else $error("Negative flag disagrees with bit 31.");

    double_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (fire && op_code == ALO_OR_DOUBLE)
        |=> negative_flag == ($past(accumulator[ACC_W-1]) | $past(operand[ACC_W-1]))
            && zero_flag == (($past(accumulator) | $past(operand)) == '0))
        else $error("Double OR flags wrong.");

    flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !fire |=> $stable(zero_flag) && $stable(negative_flag))
        else $error("Flags changed without an operation.");

    rung_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (op_valid && !rung_true && !acc_load) |=> $stable(accumulator) && !op_done)
        else $error("Operation ran with rung false.");

    stack_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (op_valid && !rung_true && !stack_push) |=> $stable(stack_top))
        else $error("Stack changed with rung false.");

    done_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fire |=> op_done)
        else $error("Taken operation gave no done pulse.");

    // Main scenarios: a stack OR, zero and negative results, a refused request, a short run.
    stack_op_c: cover property (@(posedge sys_clk) disable iff (!rst_n) pop ##1 op_done);
    zero_res_c: cover property (@(posedge sys_clk) disable iff (!rst_n) op_done && zero_flag);
    neg_res_c:  cover property (@(posedge sys_clk) disable iff (!rst_n) op_done && negative_flag);
    rung_off_c: cover property (@(posedge sys_clk) disable iff (!rst_n) op_valid && !rung_true);
    short_run_c: cover property (@(posedge sys_clk) disable iff (!rst_n) fire && bit_count == BITS_MIN);
endmodule // alo_unit

// File: test/accumulator_logic_ops_test.sv
// Purpose: Random and corner checks of the accumulator logic unit.
// Assumes: One result per taken request, one cycle later.
// Notes:   A push beside a taken op saves the old value; beside a stack OR it is dropped.
`timescale 1ns/1ns
module accumulator_logic_ops_test;
    import alo_pkg::*;
    logic            sys_clk, rst_n, op_valid, rung_true, acc_load, stack_push;
    logic            zero_flag, negative_flag, op_done, taken, e_z, e_n;
    alo_op_e         op_code;
    logic [31:0]     pair, acc_load_data, accumulator, e_acc;
    logic [5:0]      bit_count;
    logic [3:0]      addr;
    logic [15:0]     rnd;
    logic [7:0][31:0] stk;
    int              n_mismatch, total_checks;
    alo_mem_model u_mem (.addr(addr), .data(pair));
    alo_unit u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .op_valid(op_valid),
        .rung_true(rung_true), .op_code(op_code), .operand(pair), .bit_count(bit_count),
        .acc_load(acc_load), .acc_load_data(acc_load_data), .stack_push(stack_push),
        .accumulator(accumulator), .zero_flag(zero_flag), .negative_flag(negative_flag),
        .op_done(op_done));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] run(input logic [31:0] b, input logic [5:0] c);
        logic [63:0] m;
        m = (64'h1 << c) - 64'h1;
        return (c >= 6'h01 && c <= 6'h20) ? (b & m[31:0]) : 32'h0;
    endfunction
    function automatic logic [31:0] calc(input alo_op_e o, input logic [31:0] a,
        input logic [31:0] v, input logic [5:0] c, input logic [31:0] t);
        case (o)
            ALO_OR_DOUBLE:   return a | v;
            ALO_OR_BITRANGE: return a | run(v, c);
            ALO_OR_STACK:    return a | t;
            ALO_XOR_WORD:    return a ^ {16'h0000, v[15:0]};
            ALO_XOR_DOUBLE:  return a ^ v;
            default:         return a ^ run(v, c);
        endcase
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        rst_n = 1'b0;
        {op_valid, rung_true, acc_load, stack_push} = 4'h0;
        op_code = ALO_OR_DOUBLE;
        {addr, bit_count, acc_load_data} = 42'h0;
        rnd = 16'hAE85;
        {e_acc, e_z, e_n, stk} = '0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        check(accumulator, ACC_RESET);
        check({zero_flag, negative_flag, op_done}, 3'h0);
        for (int k = 0; k < 3000; k++) begin
            rnd = lfsr(rnd);
            // Corners: every op back to back, run edges, then a zero load and an empty run.
            op_valid = (k < 12 || k == 13) || (k > 13 && rnd[0]);
            rung_true = (k < 14) || rnd[1] || rnd[2];
            op_code = alo_op_e'((k < 12) ? 3'(k % 6) : (k == 13) ? 3'(ALO_XOR_BITRANGE) : 3'(rnd[5:3] % 3'h6));
            addr = rnd[9:6];
            bit_count = (k < 6) ? BITS_MAX : (k < 12) ? BITS_MIN : (k == 13) ? 6'h00 : rnd[15:10];
            rnd = lfsr(rnd);
            acc_load_data = (k == 12) ? 32'h0 : {rnd, ~rnd};
            taken = op_valid & rung_true;
            acc_load = (k == 12) || (rnd[2] && rnd[3]);
            stack_push = rnd[0];
            @(posedge sys_clk);
            if (taken && op_code == ALO_OR_STACK) begin
                e_acc = e_acc | stk[0];
                stk = {32'h0, stk[7:1]};
            end else begin
                if (stack_push) begin
                    stk = {stk[6:0], e_acc};
                end
                if (taken) begin
                    e_acc = calc(op_code, e_acc, pair, bit_count, 32'h0);
                end else if (acc_load) begin
                    e_acc = acc_load_data;
                end
            end
            if (taken) begin
                {e_z, e_n} = {e_acc == 32'h0, e_acc[31]};
            end
            @(negedge sys_clk);
            check(accumulator, e_acc);
            check(zero_flag, e_z);
            check(negative_flag, e_n);
            check(op_done, taken);
        end
        finish_test();
    end
endmodule // accumulator_logic_ops_test

// File: test/alo_mem_model.sv
// Purpose: Data memory of the instruction sequencer side.
// Assumes: Reads are combinational; the model assembles word pairs from two adjacent entries.
// Notes:   Contents are a fixed pattern, so every run is the same.
`timescale 1ns/1ns
module alo_mem_model (
    input  wire logic [3:0]  addr,
    output logic      [31:0] data
);
    logic [15:0] mem [0:16];
    initial begin
        for (int i = 0; i < 17; i++) begin
            mem[i] = (16'(i) * 16'h9E37) ^ 16'hA5C3;
        end
    end
    assign data = {mem[addr + 5'h01], mem[addr]};
endmodule // alo_mem_model
